// File: core/blx_exec.sv
// Execution unit for bit set, bit test and skip, AND with file,
// accumulator clear, subroutine call and watchdog clear.
// Assumes one instruction presented per cycle with instr_valid_i; the
// file register byte at the decoded address is read on file_rdata_i in
// the same cycle (combinational read by the surrounding core).
`timescale 1ns/100ps
`include "blx_cfg.svh"

module blx_exec #(
    parameter int STACK_DEPTH = 2,
    parameter int WDT_W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Instruction stream
    input wire logic [11:0] instr_i,
    input wire logic instr_valid_i,
    output logic instr_kill_o,
    output logic busy_o,
    // File register port
    input wire logic [7:0] file_rdata_i,
    output logic [4:0] file_addr_o,
    output logic [7:0] file_wdata_o,
    output logic file_we_o,
    // Status register bits <6:5>
    input wire logic [7:0] status_i,
    // Prescaler assignment and events
    input wire logic psa_wdt_i,
    input wire logic wdt_tick_i,
    input wire logic psc_tick_i,
    // Architectural state
    output logic [7:0] accum_o,
    output logic zero_flag_o,
    output logic timeout_flag_o,
    output logic powerdown_flag_o,
    output logic [10:0] program_counter_o,
    output logic [10:0] stack_top_o,
    output logic [WDT_W-1:0] watchdog_counter_o,
    output logic [7:0] prescaler_o
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    blx_dec_if dif();

    blx_decode u_dec (
        .instr_i(instr_i),
        .dec(dif.dec)
    );

    logic [7:0] accum_r;
    logic zero_r;
    logic to_r;
    logic pd_r;
    logic [10:0] pc_r;
    logic [WDT_W-1:0] wdt_r;
    logic [7:0] psc_r;
    logic kill_r;
    logic call2_r;

    // ----------------------------------------
    // Execute enables
    // ----------------------------------------
    logic exec;
    logic is_bsf;
    logic is_and;
    logic is_btc;
    logic is_bts;
    logic is_clear_accum_op;
    logic is_call;
    logic is_cwdt;
    logic tbit;
    logic skip;
    logic [7:0] and_res;
    logic [10:0] pc_inc;

    // A killed slot is the no-op that replaces the discarded prefetch
    assign exec = instr_valid_i && !kill_r && !call2_r;
    assign is_bsf = exec && (dif.op == blx_pkg::BLX_OP_BSF);
    assign is_and = exec && (dif.op == blx_pkg::BLX_OP_AND);
    assign is_btc = exec && (dif.op == blx_pkg::BLX_OP_BTC);
    assign is_bts = exec && (dif.op == blx_pkg::BLX_OP_BTS);
    assign is_clear_accum_op = exec && (dif.op == blx_pkg::BLX_OP_CLEAR_ACCUM_OP);
    assign is_call = exec && (dif.op == blx_pkg::BLX_OP_CALL);
    assign is_cwdt = exec && (dif.op == blx_pkg::BLX_OP_CWDT);

    assign tbit = file_rdata_i[dif.bsel];
    assign skip = (is_btc && !tbit) || (is_bts && tbit);
    assign and_res = accum_r & file_rdata_i;
    assign pc_inc = pc_r + 11'h001;

    // ----------------------------------------
    // File register write path
    // ----------------------------------------
    always_comb begin
        file_addr_o = dif.faddr;
        file_wdata_o = file_rdata_i | (8'h01 << dif.bsel);
        file_we_o = is_bsf;
        if (is_and) begin
            file_wdata_o = and_res;
            file_we_o = dif.dest_f;
        end
    end

    // ----------------------------------------
    // Accumulator and zero flag
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            accum_r <= `BLX_BYTE_ZERO;
        end else if (is_clear_accum_op) begin
            accum_r <= `BLX_BYTE_ZERO;
        end else if (is_and && !dif.dest_f) begin
            accum_r <= and_res;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            zero_r <= 1'b0;
        end else if (is_clear_accum_op) begin
            zero_r <= 1'b1;
        end else if (is_and) begin
            zero_r <= (and_res == `BLX_BYTE_ZERO);
        end
    end

    // ----------------------------------------
    // Skip and call second-cycle slots
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            kill_r <= 1'b0;
        end else if (instr_valid_i) begin
            kill_r <= skip;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            call2_r <= 1'b0;
        end else if (instr_valid_i) begin
            call2_r <= is_call;
        end
    end

    // ----------------------------------------
    // Program counter and return stack
    // ----------------------------------------
    // Push uses the pre-call counter plus one, so the stack sees the return address
    blx_stack #(
        .DEPTH(STACK_DEPTH),
        .AW(11)
    ) u_stk (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .push_i(is_call),
        .push_data_i(pc_inc),
        .pop_i(1'b0),
        .top_o(stack_top_o)
    );

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc_r <= `BLX_PC_RESET;
        end else if (is_call) begin
            pc_r <= {status_i[`BLX_ST_PAGE_MSB:`BLX_ST_PAGE_LSB], 1'b0, dif.lit};
        end else if (instr_valid_i) begin
            pc_r <= pc_inc;
        end
    end

    // ----------------------------------------
    // Watchdog, prescaler and reset-cause flags
    // ----------------------------------------
    logic tmr_wb;
    assign tmr_wb = file_we_o && (dif.faddr == `BLX_TMR_ADDR);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wdt_r <= '0;
        end else if (is_cwdt) begin
            wdt_r <= '0;
        end else if (wdt_tick_i) begin
            wdt_r <= wdt_r + 1'b1;
        end
    end

    // Clear wins over a tick arriving in the same cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            psc_r <= `BLX_BYTE_ZERO;
        end else if (is_cwdt && psa_wdt_i) begin
            psc_r <= `BLX_BYTE_ZERO;
        end else if (tmr_wb && !psa_wdt_i) begin
            psc_r <= `BLX_BYTE_ZERO;
        end else if (psc_tick_i) begin
            psc_r <= psc_r + 8'h01;
        end
    end

    // Active-low flags in the status word; one means no event seen
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            to_r <= 1'b1;
            pd_r <= 1'b1;
        end else if (is_cwdt) begin
            to_r <= 1'b1;
            pd_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign instr_kill_o = kill_r;
    assign busy_o = kill_r || call2_r;
    assign accum_o = accum_r;
    assign zero_flag_o = zero_r;
    assign timeout_flag_o = to_r;
    assign powerdown_flag_o = pd_r;
    assign program_counter_o = pc_r;
    assign watchdog_counter_o = wdt_r;
    assign prescaler_o = psc_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_call_issue;
        is_call;
    endsequence

    a_bsf_sets_bit: assert property (@(posedge clk_i) disable iff (!rstn_i)
        is_bsf |-> file_we_o && file_wdata_o[dif.bsel]
                   && ((file_wdata_o & ~(8'h01 << dif.bsel))
                       == (file_rdata_i & ~(8'h01 << dif.bsel))))
        else $error("bit set write wrong");
    a_and_dest_w: assert property (@(posedge clk_i) disable iff (!rstn_i)
        is_and && !dif.dest_f |=> accum_r == $past(and_res)
                                  && zero_r == ($past(and_res) == 8'h00))
        else $error("and result wrong");
    a_btc_skip: assert property (@(posedge clk_i) disable iff (!rstn_i)
        is_btc && !tbit |=> kill_r ##1 !kill_r)
        else $error("clear test did not skip");
    a_bts_skip: assert property (@(posedge clk_i) disable iff (!rstn_i)
        is_bts && tbit |=> kill_r && !file_we_o)
        else $error("set test did not skip");
    a_skip_nop: assert property (@(posedge clk_i) disable iff (!rstn_i)
        kill_r |-> !file_we_o && $stable(accum_r))
        else $error("discarded slot had effect");
    a_clear_accum_op_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
        is_clear_accum_op |=> accum_r == 8'h00 && zero_r)
        else $error("accumulator clear wrong");
    a_call_push: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_call_issue |=> stack_top_o == $past(pc_r) + 11'h001)
        else $error("return address wrong");
    a_call_target: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_call_issue |=> pc_r == {$past(status_i[`BLX_ST_PAGE_MSB:`BLX_ST_PAGE_LSB]),
                                  1'b0, $past(dif.lit)})
        else $error("call target wrong");
    a_call_two: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_call_issue ##1 instr_valid_i |-> busy_o && $stable(zero_r))
        else $error("call not two cycles");
    a_cwdt_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
        is_cwdt |=> wdt_r == '0 && to_r && pd_r)
        else $error("watchdog clear wrong");
    a_psc_assign: assert property (@(posedge clk_i) disable iff (!rstn_i)
        is_cwdt && !psa_wdt_i && !tmr_wb && !psc_tick_i |=> $stable(psc_r))
        else $error("prescaler cleared while unassigned");
    a_tmr_psc: assert property (@(posedge clk_i) disable iff (!rstn_i)
        tmr_wb && !psa_wdt_i |=> psc_r == 8'h00)
        else $error("timer write kept prescaler");
    a_noskip_one: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (is_btc && tbit) || (is_bts && !tbit) |=> !kill_r)
        else $error("unmet test skipped");
endmodule : blx_exec

// File: core/blx_cfg.svh
// Constants for the bit, logic, call and watchdog-clear execution unit.
// Assumes nothing; definitions only, included by bare name.
`ifndef BLX_CFG_SVH
`define BLX_CFG_SVH

// ----------------------------------------
// Opcode fields of the 12-bit instruction
// ----------------------------------------
`define BLX_OPC_BSF4     4'h5
`define BLX_OPC_BTC4     4'h6
`define BLX_OPC_BTS4     4'h7
`define BLX_OPC_CALL4    4'h9
`define BLX_OPC_AND6     6'h05
`define BLX_OPC_CLRW12   12'h040
`define BLX_OPC_CWDT12   12'h004
`define BLX_OPC_NOP12    12'h000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BLX_F_MSB        4
`define BLX_B_LSB        5
`define BLX_B_MSB        7
`define BLX_D_BIT        5
`define BLX_K_MSB        7
`define BLX_ST_PAGE_LSB  5
`define BLX_ST_PAGE_MSB  6
`define BLX_ST_Z_BIT     2

// ----------------------------------------
// Reset values and fixed addresses
// ----------------------------------------
`define BLX_BYTE_ZERO    8'h00
`define BLX_PC_RESET     11'h000
`define BLX_TMR_ADDR     5'h01

`endif

// File: core/blx_pkg.sv
// Types shared by the execution unit and its helpers.
// Assumes the cfg header is compiled alongside.
package blx_pkg;
    typedef enum logic [2:0] {
        BLX_OP_NONE,
        BLX_OP_BSF,
        BLX_OP_AND,
        BLX_OP_BTC,
        BLX_OP_BTS,
        BLX_OP_CLEAR_ACCUM_OP,
        BLX_OP_CALL,
        BLX_OP_CWDT
    } blx_op_t;
endpackage : blx_pkg

// File: core/blx_dec_if.sv
// Decoded instruction fields passed from decoder to executor.
// Assumes a single clock domain.
`timescale 1ns/100ps
interface blx_dec_if;
    blx_pkg::blx_op_t op;
    logic [4:0] faddr;
    logic [2:0] bsel;
    logic dest_f;
    logic [7:0] lit;
    modport dec (output op, faddr, bsel, dest_f, lit);
    modport exe (input op, faddr, bsel, dest_f, lit);
endinterface : blx_dec_if

// File: core/blx_decode.sv
// Combinational instruction decoder for the covered opcodes.
// Assumes a 12-bit instruction word held stable for one cycle.
`timescale 1ns/100ps
`include "blx_cfg.svh"
module blx_decode (
    // Instruction
    input wire logic [11:0] instr_i,
    // Decoded fields
    blx_dec_if.dec dec
);
    always_comb begin
        dec.faddr = instr_i[`BLX_F_MSB:0];
        dec.bsel = instr_i[`BLX_B_MSB:`BLX_B_LSB];
        dec.dest_f = instr_i[`BLX_D_BIT];
        dec.lit = instr_i[`BLX_K_MSB:0];
        if (instr_i == `BLX_OPC_CLRW12) begin
            dec.op = blx_pkg::BLX_OP_CLEAR_ACCUM_OP;
        end else if (instr_i == `BLX_OPC_CWDT12) begin
            dec.op = blx_pkg::BLX_OP_CWDT;
        end else if (instr_i[11:6] == `BLX_OPC_AND6) begin
            dec.op = blx_pkg::BLX_OP_AND;
        end else begin
            case (instr_i[11:8])
                `BLX_OPC_BSF4: dec.op = blx_pkg::BLX_OP_BSF;
                `BLX_OPC_BTC4: dec.op = blx_pkg::BLX_OP_BTC;
                `BLX_OPC_BTS4: dec.op = blx_pkg::BLX_OP_BTS;
                `BLX_OPC_CALL4: dec.op = blx_pkg::BLX_OP_CALL;
                default: dec.op = blx_pkg::BLX_OP_NONE;
            endcase
        end
    end
endmodule : blx_decode

// File: core/blx_stack.sv
// Hardware return stack, depth a parameter; oldest entry lost on overflow.
// Assumes push and pop are never requested together.
`timescale 1ns/100ps
module blx_stack #(
    parameter int DEPTH = 2,
    parameter int AW = 11
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Push and pop
    input wire logic push_i,
    input wire logic [AW-1:0] push_data_i,
    input wire logic pop_i,
    output logic [AW-1:0] top_o
);
    logic [AW-1:0] ent_r [DEPTH];

    // Shift register: a push moves every entry down one place
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_ent
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    ent_r[gi] <= '0;
                end else if (push_i) begin
                    ent_r[gi] <= (gi == 0) ? push_data_i : ent_r[(gi == 0) ? 0 : gi - 1];
                end else if (pop_i) begin
                    ent_r[gi] <= (gi == DEPTH - 1) ? ent_r[gi]
                                 : ent_r[(gi == DEPTH - 1) ? gi : gi + 1];
                end
            end
        end
    endgenerate

    assign top_o = ent_r[0];
endmodule : blx_stack

// File: test/testbench.sv
// Self-checking bench for the bit, logic, call and watchdog-clear execution unit.
// Assumes the design files and the cfg header are compiled first; the bench
// models the file register array and feeds its read port combinationally.
`timescale 1ns/100ps
module testbench;
    // Clock and reset
    logic clk_i;
    logic rstn_i;
    // Instruction stream
    logic [11:0] instr_i;
    logic instr_valid_i;
    logic instr_kill_o;
    logic busy_o;
    // File register port
    wire logic [7:0] file_rdata_i;
    logic [4:0] file_addr_o;
    logic [7:0] file_wdata_o;
    logic file_we_o;
    // Status, prescaler and state
    logic [7:0] status_i;
    logic psa_wdt_i;
    logic wdt_tick_i;
    logic psc_tick_i;
    logic [7:0] accum_o;
    logic zero_flag_o;
    logic timeout_flag_o;
    logic powerdown_flag_o;
    logic [10:0] program_counter_o;
    logic [10:0] stack_top_o;
    logic [7:0] watchdog_counter_o;
    logic [7:0] prescaler_o;

    int failures = 0;
    int n_compared = 0;
    logic [7:0] mem [32];
    logic [10:0] exp_pc = 11'h000;
    logic [10:0] exp_top = 11'h000;
    logic [11:0] prev = 12'h000;
    logic [7:0] st_prev = 8'h00;
    logic prev_v = 1'h0;
    logic call_cyc = 1'h0;
    logic tick = 1'h0;
    logic psa = 1'h0;
    logic [7:0] st = 8'h00;
    logic [7:0] hold;
    logic skip;

    blx_exec #(.STACK_DEPTH(2), .WDT_W(8)) i_dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
        .instr_kill_o(instr_kill_o), .busy_o(busy_o), .file_rdata_i(file_rdata_i),
        .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o), .file_we_o(file_we_o),
        .status_i(status_i), .psa_wdt_i(psa_wdt_i), .wdt_tick_i(wdt_tick_i),
        .psc_tick_i(psc_tick_i), .accum_o(accum_o), .zero_flag_o(zero_flag_o),
        .timeout_flag_o(timeout_flag_o), .powerdown_flag_o(powerdown_flag_o),
        .program_counter_o(program_counter_o), .stack_top_o(stack_top_o),
        .watchdog_counter_o(watchdog_counter_o), .prescaler_o(prescaler_o)
    );

    // ----------------------------------------
    // File register array
    // ----------------------------------------
    // Read is combinational, as the core around the unit provides it
    assign file_rdata_i = mem[file_addr_o];
    always @(posedge clk_i) begin
        if (file_we_o === 1'h1) begin
            mem[file_addr_o] <= file_wdata_o;
        end
    end

    initial begin
        clk_i = 1'h0;
        forever #2 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        if (failures == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    // Presents one slot at an edge; the slot before it is taken at that same edge,
    // so the program counter and return stack are checked after every slot
    task automatic issue(input logic [11:0] ins);
        @(posedge clk_i);
        instr_i <= ins;
        instr_valid_i <= 1'h1;
        status_i <= st;
        psa_wdt_i <= psa;
        wdt_tick_i <= tick;
        psc_tick_i <= tick;
        if (prev_v) begin
            if (prev[11:8] === 4'h9 && !call_cyc) begin
                exp_top = exp_pc + 11'h001;
                exp_pc = {st_prev[6:5], 1'h0, prev[7:0]};
                call_cyc = 1'h1;
            end else begin
                exp_pc = exp_pc + 11'h001;
                call_cyc = 1'h0;
            end
        end
        prev = ins;
        prev_v = 1'h1;
        st_prev = st;
        #1;
        check(program_counter_o, exp_pc);
        check(stack_top_o, exp_top);
    endtask : issue

    task automatic run_ticks(input int n);
        tick = 1'h1;
        repeat (n) issue(12'h000);
        tick = 1'h0;
        issue(12'h000);
    endtask : run_ticks

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 32; i++) mem[i] = 8'h00;
        rstn_i = 1'h0;
        instr_i = 12'h000;
        instr_valid_i = 1'h0;
        status_i = 8'h00;
        psa_wdt_i = 1'h0;
        wdt_tick_i = 1'h0;
        psc_tick_i = 1'h0;
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'h1;
        #1;
        check({accum_o, zero_flag_o, timeout_flag_o, powerdown_flag_o}, 16'h0003);
        check({watchdog_counter_o, prescaler_o}, 16'h0000);
        // AND to the accumulator first, so the zero flag moves from its reset value
        mem[16] = 8'hff;
        mem[17] = 8'ha5;
        issue({6'h05, 1'h0, 5'h10});
        check(file_we_o, 1'h0);
        issue({6'h05, 1'h1, 5'h11});
        check({accum_o, zero_flag_o}, {8'h00, 1'h1});
        check(file_we_o, 1'h1);
        issue(12'h040);
        check(mem[17], 8'h00);
        check(mem[16], 8'hff);
        issue(12'h000);
        check({accum_o, zero_flag_o}, {8'h00, 1'h1});
        // Bit set over every position, top and bottom file address
        mem[0] = 8'h80;
        for (int b = 0; b < 8; b++) begin
            issue({4'h5, 3'(b), 5'h1f});
            check(file_we_o, 1'h1);
            issue(12'h000);
            check(mem[31], 8'hff >> (7 - b));
            check(zero_flag_o, 1'h1);
        end
        issue({4'h5, 3'h0, 5'h00});
        issue(12'h000);
        check(mem[0], 8'h81);
        // Both tests against both bit values; the prefetched slot is a bit set
        for (int i = 0; i < 4; i++) begin
            skip = (i[1] == i[0]);
            mem[5] = i[0] ? 8'h10 : 8'hef;
            mem[7] = 8'h00;
            issue({i[1] ? 4'h7 : 4'h6, 3'h4, 5'h05});
            issue({4'h5, 3'h0, 5'h07});
            check(instr_kill_o, skip);
            check(busy_o, skip);
            issue(12'h000);
            check(instr_kill_o, 1'h0);
            check(mem[7], {7'h00, !skip});
            check(zero_flag_o, 1'h1);
        end
        // Two calls: the first lands with bit 9 of the next address set
        for (int i = 0; i < 2; i++) begin
            st = i ? 8'h40 : 8'h20;
            issue({4'h9, i ? 8'h00 : 8'hff});
            issue(12'h000);
            check(busy_o, 1'h1);
            issue(12'h000);
            check(busy_o, 1'h0);
            check(zero_flag_o, 1'h1);
        end
        // Watchdog clear with the prescaler on the watchdog, then on the timer
        psa = 1'h1;
        run_ticks(3);
        check(watchdog_counter_o != 8'h00, 1'h1);
        check(prescaler_o != 8'h00, 1'h1);
        issue(12'h004);
        issue(12'h000);
        check(watchdog_counter_o, 8'h00);
        check(prescaler_o, 8'h00);
        check({timeout_flag_o, powerdown_flag_o}, 2'h3);
        psa = 1'h0;
        run_ticks(3);
        issue(12'h004);
        hold = prescaler_o;
        issue(12'h000);
        check(watchdog_counter_o, 8'h00);
        check(prescaler_o, hold);
        check(prescaler_o != 8'h00, 1'h1);
        // Write-back to the timer register clears a prescaler assigned to it
        issue({4'h5, 3'h0, 5'h01});
        issue(12'h000);
        check(prescaler_o, 8'h00);
        end_of_test();
    end

    // Guards against a hung run
    initial begin
        repeat (3000) @(posedge clk_i);
        failures++;
        end_of_test();
    end
endmodule : testbench
